// [logic/rx_pause_pkg.sv]
// constants shared by the receive pause filter and its helpers
// assumes a byte-wide receive stream with the frame check sequence removed
package rx_pause_pkg;
	// byte offsets of frame fields, counted from the first destination byte
	localparam int DA_OFF = 0;
	localparam int SA_OFF = 6;
	localparam int TYPE_OFF = 12;
	localparam int OP_OFF = 14;
	localparam int ARG_OFF = 16;
	localparam int QUANTA_OFF = 18;
	localparam int ADDR_BYTES = 6;
	localparam int FIELD_BYTES = 2;

	// widths, counts and bit positions
	localparam int CNT_W = 16;
	localparam int QUANTA_W = 16;
	localparam int NUM_VALID = 9;
	localparam int GLOB_IDX = 8;
	localparam int MCAST_BIT = 40;

	// fixed field values
	localparam logic [15:0] VLAN_TPID = 16'h8100;
	localparam logic [15:0] GLOB_OPCODE_NOM = 16'h0001;
	localparam logic [15:0] PRIO_OPCODE_NOM = 16'h0101;
	localparam logic [15:0] LEN_TYPE_SPLIT = 16'h0600;
	localparam logic [47:0] BCAST_ADDR = 48'hffffffffffff;

	// length bounds in bytes
	localparam logic [15:0] HDR_BYTES = 16'h000e;
	localparam logic [15:0] MIN_PAYLOAD = 16'h002e;
	localparam logic [15:0] MIN_GLOB_BYTES = 16'h0012;
	localparam logic [15:0] MIN_PRIO_BYTES = 16'h0022;

	// frame tracking states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_FRAME = 3'h2,
		ST_EVAL = 3'h4
	} frame_state_e;
endpackage

// [logic/rx_field_grab.sv]
// captures a fixed run of bytes of the receive stream into a register
// assumes the caller supplies the byte position of the current beat
module rx_field_grab import rx_pause_pkg::*; #(
	parameter int OFFSET = 0,
	parameter int BYTES = 2
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// byte stream
	input wire logic i_take,
	input wire logic [CNT_W-1:0] i_pos,
	input wire logic [7:0] i_data,
	// captured field, first byte in the upper bits
	output logic [BYTES*8-1:0] o_value
);
	localparam logic [CNT_W-1:0] FIRST = CNT_W'(OFFSET);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(OFFSET + BYTES);

	// shifting needs at least two bytes of room
	if (BYTES < 2 || OFFSET < 0) begin : g_bad
		$error("rx_field_grab: BYTES must be 2 or more");
	end

	wire logic in_span = i_take && (i_pos >= FIRST) && (i_pos < LAST);

	// network order: earlier bytes end up more significant
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_value <= '0;
		end else if (in_span) begin
			o_value <= {o_value[BYTES*8-9:0], i_data};
		end
	end
endmodule

// [logic/rx_pause_match.sv]
// qualifies a pause candidate against the configured address, type, opcode
// assumes all fields are stable while the result is read
module rx_pause_match (
	// check enables
	input wire logic i_mc_chk_en,
	input wire logic i_uc_chk_en,
	input wire logic i_src_chk_en,
	input wire logic i_type_chk_en,
	input wire logic i_op_chk_en,
	// configured values
	input wire logic [47:0] i_mc_addr,
	input wire logic [47:0] i_uc_addr,
	input wire logic [47:0] i_src_addr,
	input wire logic [15:0] i_type,
	input wire logic [15:0] i_opcode,
	// frame fields
	input wire logic [47:0] i_frame_da,
	input wire logic [47:0] i_frame_sa,
	input wire logic [15:0] i_frame_type,
	input wire logic [15:0] i_frame_op,
	// all enabled checks passed
	output logic o_pass
);
	// a disabled check always passes
	wire logic mc_ok = !i_mc_chk_en || (i_frame_da == i_mc_addr);
	wire logic uc_ok = !i_uc_chk_en || (i_frame_da == i_uc_addr);
	wire logic sa_ok = !i_src_chk_en || (i_frame_sa == i_src_addr);
	wire logic ty_ok = !i_type_chk_en || (i_frame_type == i_type);
	wire logic op_ok = !i_op_chk_en || (i_frame_op == i_opcode);

	assign o_pass = mc_ok && uc_ok && sa_ok && ty_ok && op_ok;
endmodule

// [logic/rx_pause_frame_filter_stats.sv]
// receive pause qualification and per-packet statistics pulses
// assumes a byte stream in the receive clock domain, FCS already stripped,
// with the FCS verdict valid on the last beat of each frame
// How it works
// - global multicast check on: destination must equal multicast pause address.
// - global unicast check on: destination must equal unicast pause address.
// - global source check on: source must equal configured pause source.
// - global type check on: ethertype must equal configured global value.
// - global opcode check on: opcode must equal configured global value.
// - priority pause frames are handled only while priority enable is high.
// - priority multicast check on: destination equals multicast pause address.
// - priority unicast check on: destination equals unicast pause address.
// - priority source check on: source equals configured pause source.
// - priority type check on: ethertype equals configured priority value.
// - priority opcode check on: opcode equals configured priority value.
// - pulse once per good unicast packet.
// - pulse once per good multicast packet other than broadcast.
// - pulse once per good broadcast packet.
// - pulse once per good VLAN tagged packet.
// - pulse once per global pause packet with good FCS.
// - pulse once per priority pause packet with good FCS.
// - pulse once per good-FCS packet whose length field is wrong.
// - accepted pause sets its valid bit; global pause uses bit 8.
// - sixteen-bit quanta per priority, global quanta in entry 8.
// - accepted pause raises its request bit until the user marks it done.
module rx_pause_frame_filter_stats import rx_pause_pkg::*; #(
	parameter int NUM_PRIO = 8
) (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	// receive byte stream
	input wire logic I_RX_VALID,
	input wire logic [7:0] I_RX_DATA,
	input wire logic I_RX_SOP,
	input wire logic I_RX_EOP,
	input wire logic I_RX_FCS_OK,
	// global pause qualification
	input wire logic I_GLOB_PAUSE_MC_CHK_EN,
	input wire logic I_GLOB_PAUSE_UC_CHK_EN,
	input wire logic I_GLOB_PAUSE_SRC_CHK_EN,
	input wire logic I_GLOB_PAUSE_TYPE_CHK_EN,
	input wire logic [15:0] I_GLOB_PAUSE_TYPE,
	input wire logic I_GLOB_PAUSE_OP_CHK_EN,
	input wire logic [15:0] I_GLOB_PAUSE_OPCODE,
	// priority pause qualification
	input wire logic I_PRIO_PAUSE_EN,
	input wire logic I_PRIO_PAUSE_MC_CHK_EN,
	input wire logic I_PRIO_PAUSE_UC_CHK_EN,
	input wire logic I_PRIO_PAUSE_SRC_CHK_EN,
	input wire logic I_PRIO_PAUSE_TYPE_CHK_EN,
	input wire logic [15:0] I_PRIO_PAUSE_TYPE,
	input wire logic I_PRIO_PAUSE_OP_CHK_EN,
	input wire logic [15:0] I_PRIO_PAUSE_OPCODE,
	// pause addresses
	input wire logic [47:0] I_PAUSE_UC_DEST_ADDR,
	input wire logic [47:0] I_PAUSE_MC_DEST_ADDR,
	input wire logic [47:0] I_PAUSE_SRC_ADDR,
	// pause request release
	input wire logic [NUM_VALID-1:0] I_PAUSE_DONE,
	// statistics pulses
	output logic O_STAT_UNICAST,
	output logic O_STAT_MULTICAST,
	output logic O_STAT_BROADCAST,
	output logic O_STAT_VLAN,
	output logic O_STAT_GLOB_PAUSE,
	output logic O_STAT_PRIO_PAUSE,
	output logic O_STAT_LEN_ERR,
	// pause results
	output logic [NUM_VALID-1:0] O_PAUSE_VALID,
	output logic [NUM_VALID-1:0][QUANTA_W-1:0] O_PAUSE_QUANTA_PRIO,
	output logic [NUM_VALID-1:0] O_PAUSE_REQ
);
	// the frame layout carries at most eight priority classes
	if (NUM_PRIO < 1 || NUM_PRIO > GLOB_IDX) begin : g_bad_prio
		$error("NUM_PRIO must lie between 1 and 8");
	end

	frame_state_e state;
	frame_state_e next_state;

	logic [CNT_W-1:0] byte_cnt;
	logic [CNT_W-1:0] frame_len;
	logic fcs_ok;

	// captured fields
	logic [47:0] f_da;
	logic [47:0] f_sa;
	logic [15:0] f_type;
	logic [15:0] f_op;
	logic [15:0] f_arg;
	logic [GLOB_IDX-1:0][QUANTA_W-1:0] f_quanta;

	// position of the current beat; a start beat always restarts at zero
	wire logic [CNT_W-1:0] cur_pos = I_RX_SOP ? '0 : byte_cnt;
	wire logic in_frame = I_RX_SOP || (state == ST_FRAME);
	wire logic take = I_RX_VALID && in_frame;
	wire logic last_beat = take && I_RX_EOP;
	wire logic cnt_full = &cur_pos;
	wire logic [CNT_W-1:0] pos_inc = cnt_full ? cur_pos : cur_pos + 1'b1;

	// frame tracking: idle, inside a frame, one cycle of evaluation
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (take) begin
					next_state = I_RX_EOP ? ST_EVAL : ST_FRAME;
				end
			end
			ST_FRAME: begin
				if (last_beat) begin
					next_state = ST_EVAL;
				end
			end
			ST_EVAL: begin
				// back to back frames may start during evaluation
				if (take) begin
					next_state = I_RX_EOP ? ST_EVAL : ST_FRAME;
				end else begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// byte counter saturates so giant frames cannot wrap into a header
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			byte_cnt <= '0;
		end else if (take) begin
			byte_cnt <= pos_inc;
		end
	end

	// length and FCS verdict held for the evaluation cycle
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			frame_len <= '0;
			fcs_ok <= 1'b0;
		end else if (last_beat) begin
			frame_len <= pos_inc;
			fcs_ok <= I_RX_FCS_OK;
		end
	end

	// header field capture
	rx_field_grab #(.OFFSET(DA_OFF), .BYTES(ADDR_BYTES)) u_grab_da (
		.i_clk(I_CORE_CLK),
		.i_rstn(I_RSTN),
		.i_take(take),
		.i_pos(cur_pos),
		.i_data(I_RX_DATA),
		.o_value(f_da)
	);

	rx_field_grab #(.OFFSET(SA_OFF), .BYTES(ADDR_BYTES)) u_grab_sa (
		.i_clk(I_CORE_CLK),
		.i_rstn(I_RSTN),
		.i_take(take),
		.i_pos(cur_pos),
		.i_data(I_RX_DATA),
		.o_value(f_sa)
	);

	rx_field_grab #(.OFFSET(TYPE_OFF), .BYTES(FIELD_BYTES)) u_grab_type (
		.i_clk(I_CORE_CLK),
		.i_rstn(I_RSTN),
		.i_take(take),
		.i_pos(cur_pos),
		.i_data(I_RX_DATA),
		.o_value(f_type)
	);

	rx_field_grab #(.OFFSET(OP_OFF), .BYTES(FIELD_BYTES)) u_grab_op (
		.i_clk(I_CORE_CLK),
		.i_rstn(I_RSTN),
		.i_take(take),
		.i_pos(cur_pos),
		.i_data(I_RX_DATA),
		.o_value(f_op)
	);

	// global quanta or priority class vector share this field
	rx_field_grab #(.OFFSET(ARG_OFF), .BYTES(FIELD_BYTES)) u_grab_arg (
		.i_clk(I_CORE_CLK),
		.i_rstn(I_RSTN),
		.i_take(take),
		.i_pos(cur_pos),
		.i_data(I_RX_DATA),
		.o_value(f_arg)
	);

	// per-priority quanta; all eight slots exist in the frame regardless
	for (genvar p = 0; p < GLOB_IDX; p++) begin : g_quanta
		rx_field_grab #(
			.OFFSET(QUANTA_OFF + p * FIELD_BYTES),
			.BYTES(FIELD_BYTES)
		) u_grab_q (
			.i_clk(I_CORE_CLK),
			.i_rstn(I_RSTN),
			.i_take(take),
			.i_pos(cur_pos),
			.i_data(I_RX_DATA),
			.o_value(f_quanta[p])
		);
	end

	// frame classification, read only in the evaluation cycle
	wire logic da_mcast = f_da[MCAST_BIT];
	wire logic da_bcast = (f_da == BCAST_ADDR);
	wire logic is_vlan = (f_type == VLAN_TPID);
	wire logic is_glob = (f_op == GLOB_OPCODE_NOM) &&
		(frame_len >= MIN_GLOB_BYTES);
	wire logic is_prio = (f_op == PRIO_OPCODE_NOM) &&
		(frame_len >= MIN_PRIO_BYTES);

	// length field check; short payloads may carry padding
	wire logic is_len = (f_type < LEN_TYPE_SPLIT);
	wire logic [CNT_W-1:0] payload = (frame_len > HDR_BYTES) ?
		frame_len - HDR_BYTES : '0;
	wire logic len_bad = is_len && ((f_type > payload) ||
		((payload > MIN_PAYLOAD) && (f_type != payload)));

	logic glob_pass;
	logic prio_pass;

	rx_pause_match u_glob_match (
		.i_mc_chk_en(I_GLOB_PAUSE_MC_CHK_EN),
		.i_uc_chk_en(I_GLOB_PAUSE_UC_CHK_EN),
		.i_src_chk_en(I_GLOB_PAUSE_SRC_CHK_EN),
		.i_type_chk_en(I_GLOB_PAUSE_TYPE_CHK_EN),
		.i_op_chk_en(I_GLOB_PAUSE_OP_CHK_EN),
		.i_mc_addr(I_PAUSE_MC_DEST_ADDR),
		.i_uc_addr(I_PAUSE_UC_DEST_ADDR),
		.i_src_addr(I_PAUSE_SRC_ADDR),
		.i_type(I_GLOB_PAUSE_TYPE),
		.i_opcode(I_GLOB_PAUSE_OPCODE),
		.i_frame_da(f_da),
		.i_frame_sa(f_sa),
		.i_frame_type(f_type),
		.i_frame_op(f_op),
		.o_pass(glob_pass)
	);

	rx_pause_match u_prio_match (
		.i_mc_chk_en(I_PRIO_PAUSE_MC_CHK_EN),
		.i_uc_chk_en(I_PRIO_PAUSE_UC_CHK_EN),
		.i_src_chk_en(I_PRIO_PAUSE_SRC_CHK_EN),
		.i_type_chk_en(I_PRIO_PAUSE_TYPE_CHK_EN),
		.i_op_chk_en(I_PRIO_PAUSE_OP_CHK_EN),
		.i_mc_addr(I_PAUSE_MC_DEST_ADDR),
		.i_uc_addr(I_PAUSE_UC_DEST_ADDR),
		.i_src_addr(I_PAUSE_SRC_ADDR),
		.i_type(I_PRIO_PAUSE_TYPE),
		.i_opcode(I_PRIO_PAUSE_OPCODE),
		.i_frame_da(f_da),
		.i_frame_sa(f_sa),
		.i_frame_type(f_type),
		.i_frame_op(f_op),
		.o_pass(prio_pass)
	);

	// acceptance only on the evaluation cycle with a good FCS
	wire logic eval_good = (state == ST_EVAL) && fcs_ok;
	wire logic glob_accept = eval_good && is_glob && glob_pass;
	wire logic prio_seen = eval_good && is_prio && I_PRIO_PAUSE_EN;
	wire logic prio_accept = prio_seen && prio_pass;

	// which valid bits a pause sets: bit 8 global, class vector otherwise
	logic [NUM_VALID-1:0] set_mask;
	always_comb begin
		set_mask = '0;
		for (int p = 0; p < NUM_PRIO; p++) begin
			set_mask[p] = prio_accept && f_arg[p];
		end
		set_mask[GLOB_IDX] = glob_accept;
	end

	// statistics pulses last exactly the one cycle after evaluation
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_STAT_UNICAST <= 1'b0;
			O_STAT_MULTICAST <= 1'b0;
			O_STAT_BROADCAST <= 1'b0;
			O_STAT_VLAN <= 1'b0;
			O_STAT_GLOB_PAUSE <= 1'b0;
			O_STAT_PRIO_PAUSE <= 1'b0;
			O_STAT_LEN_ERR <= 1'b0;
		end else begin
			O_STAT_UNICAST <= eval_good && !da_mcast;
			O_STAT_MULTICAST <= eval_good && da_mcast && !da_bcast;
			O_STAT_BROADCAST <= eval_good && da_bcast;
			O_STAT_VLAN <= eval_good && is_vlan;
			O_STAT_GLOB_PAUSE <= eval_good && is_glob;
			O_STAT_PRIO_PAUSE <= prio_seen;
			O_STAT_LEN_ERR <= eval_good && len_bad;
		end
	end

	// valid pulses once per accepted pause, quanta hold until replaced
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_PAUSE_VALID <= '0;
		end else begin
			O_PAUSE_VALID <= set_mask;
		end
	end

	for (genvar p = 0; p < NUM_VALID; p++) begin : g_out
		// global quanta reuse the argument field, others their own slot
		wire logic [QUANTA_W-1:0] new_q = (p == GLOB_IDX) ? f_arg :
			f_quanta[p % GLOB_IDX];

		always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
			if (!I_RSTN) begin
				O_PAUSE_QUANTA_PRIO[p] <= '0;
			end else if (set_mask[p]) begin
				O_PAUSE_QUANTA_PRIO[p] <= new_q;
			end
		end

		// a new pause wins over a release in the same cycle
		always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
			if (!I_RSTN) begin
				O_PAUSE_REQ[p] <= 1'b0;
			end else if (set_mask[p]) begin
				O_PAUSE_REQ[p] <= 1'b1;
			end else if (I_PAUSE_DONE[p]) begin
				O_PAUSE_REQ[p] <= 1'b0;
			end
		end
	end
endmodule

// [sim/rx_pause_filter_chk.sv]
// assertions on the ports of the receive pause filter
// assumes one clock domain and an active-low asynchronous reset
module rx_pause_filter_chk import rx_pause_pkg::*; #(
	parameter int NUM_PRIO = 8
) (
	// clock, reset and stream
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	input wire logic I_RX_VALID,
	input wire logic I_RX_EOP,
	input wire logic I_RX_FCS_OK,
	// control
	input wire logic I_PRIO_PAUSE_EN,
	input wire logic [NUM_VALID-1:0] I_PAUSE_DONE,
	// results
	input wire logic O_STAT_UNICAST,
	input wire logic O_STAT_MULTICAST,
	input wire logic O_STAT_BROADCAST,
	input wire logic O_STAT_VLAN,
	input wire logic O_STAT_GLOB_PAUSE,
	input wire logic O_STAT_PRIO_PAUSE,
	input wire logic O_STAT_LEN_ERR,
	input wire logic [NUM_VALID-1:0] O_PAUSE_VALID,
	input wire logic [NUM_VALID-1:0] O_PAUSE_REQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RSTN);
	// frame end with good check sequence, two edges before any pulse
	logic good_eop;
	assign good_eop = I_RX_VALID & I_RX_EOP & I_RX_FCS_OK;

	a_uc_cause: assert property (O_STAT_UNICAST |-> $past(good_eop, 2))
		else $error("unicast pulse without good frame end");
	a_mc_only: assert property (O_STAT_MULTICAST |->
		!O_STAT_BROADCAST && !O_STAT_UNICAST && $past(good_eop, 2))
		else $error("multicast pulse wrong");
	a_bc_cause: assert property (O_STAT_BROADCAST |-> $past(good_eop, 2))
		else $error("broadcast pulse without good frame end");
	a_vlan_pulse: assert property (O_STAT_VLAN |=> !O_STAT_VLAN)
		else $error("vlan pulse longer than one cycle");
	a_glob_valid: assert property (O_PAUSE_VALID[GLOB_IDX] |->
		O_STAT_GLOB_PAUSE && $past(good_eop, 2))
		else $error("global valid without global pause pulse");
	a_prio_valid: assert property ((|O_PAUSE_VALID[7:0]) |->
		O_STAT_PRIO_PAUSE && $past(I_PRIO_PAUSE_EN))
		else $error("priority valid without enabled priority pause");
	a_len_cause: assert property (O_STAT_LEN_ERR |-> $past(good_eop, 2))
		else $error("length error pulse without good frame end");
	a_glob_single: assert property (O_STAT_GLOB_PAUSE |=>
		!O_STAT_GLOB_PAUSE)
		else $error("global pause pulse longer than one cycle");
	a_req_set: assert property ((|O_PAUSE_VALID) |->
		(O_PAUSE_REQ & O_PAUSE_VALID) == O_PAUSE_VALID)
		else $error("valid bit without request bit");
	a_req_hold: assert property (O_PAUSE_REQ[GLOB_IDX] &&
		!I_PAUSE_DONE[GLOB_IDX] |=> O_PAUSE_REQ[GLOB_IDX])
		else $error("request dropped without done");
endmodule

// [sim/pause_user_model.sv]
// user flow-control logic and statistics counters beside the filter
// assumes one-cycle pulses and a bench that clears counts between frames
module pause_user_model import rx_pause_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// from the filter
	input wire logic [6:0] i_stat,
	input wire logic [NUM_VALID-1:0] i_valid,
	input wire logic [NUM_VALID-1:0][QUANTA_W-1:0] i_quanta,
	input wire logic [NUM_VALID-1:0] i_req,
	// bench control
	input wire logic i_slow,
	input wire logic i_clr,
	// release and observations
	output logic [NUM_VALID-1:0] o_done,
	output logic [6:0][7:0] o_cnt,
	output logic [NUM_VALID-1:0][QUANTA_W-1:0] o_quanta,
	output logic [NUM_VALID-1:0] o_vseen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] wait_cnt;
	// counters and quanta; quanta only taken under valid
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cnt <= '0;
			o_vseen <= '0;
		end else if (i_clr) begin
			o_cnt <= '0;
			o_vseen <= '0;
		end else begin
			o_vseen <= o_vseen | i_valid;
			for (int k = 0; k < 7; k++) begin
				o_cnt[k] <= o_cnt[k] + 8'(i_stat[k]);
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_quanta <= '0;
		end else begin
			for (int k = 0; k < NUM_VALID; k++) begin
				if (i_valid[k]) begin
					o_quanta[k] <= i_quanta[k];
				end
			end
		end
	end
	// service delay: slow mode holds requests long enough to watch them
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wait_cnt <= '0;
			o_done <= '0;
		end else if (o_done != '0 || i_req == '0) begin
			wait_cnt <= '0;
			o_done <= '0;
		end else if (wait_cnt == (i_slow ? 5'h14 : 5'h01)) begin
			o_done <= i_req;
		end else begin
			wait_cnt <= wait_cnt + 5'h01;
		end
	end
endmodule

// [sim/rx_pause_frame_filter_stats_tb.sv]
// bench for the receive pause filter: frame table, then hand cases
// assumes the user model on the pause outputs and the checker bound below
module rx_pause_frame_filter_stats_tb import rx_pause_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [12:0] cfg;
		logic [47:0] da;
		logic [47:0] sa;
		logic [15:0] ty;
		logic [15:0] op;
		logic [6:0] st;
		logic [8:0] vld;
	} row_s;
	// configured addresses supplied by the bench
	localparam logic [47:0] MC = 48'h0180c2000001;
	localparam logic [47:0] UC = 48'h0a1b2c3d4e5f;
	localparam logic [47:0] SA = 48'h02aa00000001;
	localparam logic [47:0] SX = 48'h02aa00000002;
	localparam logic [15:0] T = 16'h8808;
	localparam logic [15:0] GO = GLOB_OPCODE_NOM;
	localparam logic [15:0] PO = PRIO_OPCODE_NOM;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rx_valid = 1'b0;
	logic rx_sop = 1'b0;
	logic rx_eop = 1'b0;
	logic rx_fcs = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic [12:0] cfg = 13'h0000;
	logic slow = 1'b0;
	logic clr = 1'b0;
	logic [6:0] stat;
	logic [8:0] valid, req, done, vseen;
	logic [8:0][15:0] quanta, seen_q;
	logic [6:0][7:0] cnt;
	int mismatches = 0;
	int n_compared = 0;
	// cfg: [12] bad check sequence, [11] wrong opcodes, [10] priority on,
	// [9:5] priority mc uc src type op, [4:0] global mc uc src type op
	row_s rows [20] = '{
		'{13'h017, MC, SA, T, GO, 7'b0100100, 9'h100},
		'{13'h004, MC, SX, T, GO, 7'b0100100, 9'h000},
		'{13'h008, UC, SA, T, GO, 7'b1000100, 9'h100},
		'{13'h008, MC, SA, T, GO, 7'b0100100, 9'h000},
		'{13'h002, MC, SA, 16'h8809, GO, 7'b0100100, 9'h000},
		'{13'h801, MC, SA, T, GO, 7'b0100100, 9'h000},
		'{13'h010, UC, SA, T, GO, 7'b1000100, 9'h000},
		'{13'h000, UC, SX, 16'h8809, GO, 7'b1000100, 9'h100},
		'{13'h6e0, MC, SA, T, PO, 7'b0100010, 9'h005},
		'{13'h2e0, MC, SA, T, PO, 7'b0100000, 9'h000},
		'{13'h500, MC, SA, T, PO, 7'b0100010, 9'h000},
		'{13'h500, UC, SA, T, PO, 7'b1000010, 9'h005},
		'{13'h600, UC, SA, T, PO, 7'b1000010, 9'h000},
		'{13'h480, MC, SX, T, PO, 7'b0100010, 9'h000},
		'{13'h440, MC, SA, 16'h8809, PO, 7'b0100010, 9'h000},
		'{13'hc20, MC, SA, T, PO, 7'b0100010, 9'h000},
		'{13'h000, BCAST_ADDR, SA, 16'h0800, 16'h0, 7'b0010000, 9'h000},
		'{13'h000, UC, SA, VLAN_TPID, 16'h0, 7'b1001000, 9'h000},
		'{13'h000, UC, SA, 16'h0040, 16'h0, 7'b1000001, 9'h000},
		'{13'h1017, MC, SA, T, GO, 7'b0000000, 9'h000}
	};

	always #4 clk = ~clk;

	rx_pause_frame_filter_stats #(.NUM_PRIO(8)) DUT (
		.I_CORE_CLK(clk), .I_RSTN(rstn), .I_RX_VALID(rx_valid),
		.I_RX_DATA(rx_data), .I_RX_SOP(rx_sop), .I_RX_EOP(rx_eop),
		.I_RX_FCS_OK(~cfg[12] & rx_fcs),
		.I_GLOB_PAUSE_MC_CHK_EN(cfg[4]), .I_GLOB_PAUSE_UC_CHK_EN(cfg[3]),
		.I_GLOB_PAUSE_SRC_CHK_EN(cfg[2]), .I_GLOB_PAUSE_TYPE_CHK_EN(cfg[1]),
		.I_GLOB_PAUSE_TYPE(T), .I_GLOB_PAUSE_OP_CHK_EN(cfg[0]),
		.I_GLOB_PAUSE_OPCODE(cfg[11] ? 16'h0002 : GO),
		.I_PRIO_PAUSE_EN(cfg[10]), .I_PRIO_PAUSE_MC_CHK_EN(cfg[9]),
		.I_PRIO_PAUSE_UC_CHK_EN(cfg[8]), .I_PRIO_PAUSE_SRC_CHK_EN(cfg[7]),
		.I_PRIO_PAUSE_TYPE_CHK_EN(cfg[6]), .I_PRIO_PAUSE_TYPE(T),
		.I_PRIO_PAUSE_OP_CHK_EN(cfg[5]),
		.I_PRIO_PAUSE_OPCODE(cfg[11] ? 16'h0002 : PO),
		.I_PAUSE_UC_DEST_ADDR(UC), .I_PAUSE_MC_DEST_ADDR(MC),
		.I_PAUSE_SRC_ADDR(SA), .I_PAUSE_DONE(done),
		.O_STAT_UNICAST(stat[6]), .O_STAT_MULTICAST(stat[5]),
		.O_STAT_BROADCAST(stat[4]), .O_STAT_VLAN(stat[3]),
		.O_STAT_GLOB_PAUSE(stat[2]), .O_STAT_PRIO_PAUSE(stat[1]),
		.O_STAT_LEN_ERR(stat[0]), .O_PAUSE_VALID(valid),
		.O_PAUSE_QUANTA_PRIO(quanta), .O_PAUSE_REQ(req)
	);
	pause_user_model u_user (
		.i_clk(clk), .i_rstn(rstn), .i_stat(stat), .i_valid(valid),
		.i_quanta(quanta), .i_req(req), .i_slow(slow), .i_clr(clr),
		.o_done(done), .o_cnt(cnt), .o_quanta(seen_q), .o_vseen(vseen)
	);

	task automatic end_sim();
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// counts must match exactly, an unknown count is a mismatch
	task automatic chk_cnt(input string nm, input logic [7:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic prep(input logic [12:0] c);
		@(posedge clk);
		cfg <= c;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	// 60-byte frame; quanta p at bytes 18+2p, global quanta at 16
	task automatic send(input row_s r);
		logic [479:0] fr;
		fr = {r.da, r.sa, r.ty, r.op, (r.op == GO) ? 16'h1234 : 16'h0005,
			336'h0};
		for (int p = 0; p < 8; p++)
			fr[479 - 8 * (18 + 2 * p) -: 16] = 16'h1000 + 16'(p);
		for (int i = 0; i < 60; i++) begin
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_sop <= (i == 0);
			rx_eop <= (i == 59);
			rx_fcs <= 1'b1;
			rx_data <= fr[479 - 8 * i -: 8];
		end
	endtask
	// close the last beat so it is not sampled twice, then let pulses land
	task automatic drain();
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_eop <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic run(input row_s r);
		prep(r.cfg);
		send(r);
		drain();
	endtask

	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		foreach (rows[n]) begin
			run(rows[n]);
			for (int k = 0; k < 7; k++)
				chk_cnt("stat", 8'(rows[n].st[k]), cnt[k]);
			chk("valid", 16'(rows[n].vld), 16'(vseen));
			for (int k = 0; k < 9; k++)
				if (rows[n].vld[k])
					chk("quanta", (k == 8) ? 16'h1234 : 16'h1000 + 16'(k),
						seen_q[k]);
		end
		// slow service: request stays up, then drops after done
		slow <= 1'b1;
		run(rows[0]);
		chk("request held", 16'h0001, 16'(req[8]));
		repeat (30) @(posedge clk);
		chk("request released", 16'h0000, 16'(req[8]));
		// back-to-back frames, second starting right after the first ends
		slow <= 1'b0;
		run(rows[0]);
		prep(13'h6e0);
		send(rows[0]);
		send(rows[0]);
		drain();
		chk("valid", 16'h0100, 16'(vseen));
		chk_cnt("global pulses", 8'h02, cnt[2]);
		run(rows[8]);
		chk("valid", 16'h0005, 16'(vseen));
		chk_cnt("priority pulses", 8'h01, cnt[1]);
		// reset while a request is pending
		slow <= 1'b1;
		run(rows[0]);
		rstn <= 1'b0;
		@(posedge clk);
		chk("request in reset", 16'h0000, 16'(req));
		chk("quanta in reset", 16'h0000, quanta[8]);
		rstn <= 1'b1;
		slow <= 1'b0;
		run(rows[2]);
		chk("valid after reset", 16'h0100, 16'(vseen));
		end_sim();
	end
endmodule

bind rx_pause_frame_filter_stats rx_pause_filter_chk
	#(.NUM_PRIO(NUM_PRIO)) u_chk (.*);
